// ===== hw/rsq_debounce.sv
// Purpose: Debounce filter for the manual reset pushbutton
// Assumes: Input already synchronous to pclk
// Notes:   Output flips only after the input differs for QUAL_CYCLES in a row
`timescale 1ns/1ps
`default_nettype none
module rsq_debounce #(
  parameter int unsigned QUAL_CYCLES = rsq_pkg::QUALIFY_CYCLES
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Level in and out
  input  wire logic raw_level,
  output logic      clean_level
);

  logic [17:0] run_q;
  logic        differ;

  assign differ = raw_level != clean_level;

  // Bounce shorter than the window restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 18'h00000;
    end else if (!differ || run_q == 18'(QUAL_CYCLES - 1)) begin
      run_q <= 18'h00000;
    end else begin
      run_q <= run_q + 18'h00001;
    end
  end

  // Idle level is high, the not-pressed state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clean_level <= 1'b1;
    end else if (differ && run_q == 18'(QUAL_CYCLES - 1)) begin
      clean_level <= raw_level;
    end
  end

  a_qualify_window: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(clean_level) |-> $past(run_q) == 18'(QUAL_CYCLES - 1))
    else $error("Button level changed before qualify window");

endmodule
`default_nettype wire

// ===== hw/rsq_sequencer.sv
// Purpose: Staged release of three active-low resets with APB status and control
// Assumes: Supply comparator flags and straps arrive synchronous to pclk
// Notes:   Delay and margin straps are 2-bit codes for tied low, tied high, floating
`timescale 1ns/1ps
`default_nettype none
module rsq_sequencer #(
  parameter int unsigned TICK_CYCLES_P    = rsq_pkg::TICK_CYCLES,
  parameter int unsigned QUALIFY_CYCLES_P = rsq_pkg::QUALIFY_CYCLES,
  parameter bit          LOW_VOLT_VARIANT = 1'b0
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Supply comparator
  input  wire logic        supply_fail,
  input  wire logic        supply_below_min,
  // Straps
  input  wire logic [1:0]  delay_select,
  input  wire logic [1:0]  supply_margin_select,
  // Pushbutton
  input  wire logic        manual_reset_button_n,
  input  wire logic        button_driven,
  // Reset outputs and trip select
  output logic             first_reset_out_n,
  output logic             second_reset_out_n,
  output logic             third_reset_out_n,
  output logic      [1:0]  supply_trip_level
);

  typedef enum logic [1:0] {ST_HOLD, ST_RELEASE, ST_DONE} rsq_state_e;

  rsq_state_e  state_q;
  logic [16:0] presc_q;
  logic [9:0]  ms_cnt_q;
  logic [9:0]  base_q;
  logic [9:0]  second_ms;
  logic [9:0]  third_ms;
  logic        tick;
  logic        soft_hold_q;
  logic        button_raw;
  logic        button_clean;
  logic        button_pressed;
  logic        cause;
  logic        access;
  logic        complete;
  logic        mapped;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Pushbutton

  // Undriven pad reads as the pulled-up, not-pressed level
  assign button_raw = manual_reset_button_n | ~button_driven;

  rsq_debounce #(
    .QUAL_CYCLES (QUALIFY_CYCLES_P)
  ) u_debounce (
    .pclk        (pclk),
    .presetn     (presetn),
    .raw_level   (button_raw),
    .clean_level (button_clean)
  );

  assign button_pressed = ~button_clean;

  // Any cause forces the hold state; press works from any state
  assign cause = supply_fail | button_pressed | soft_hold_q;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase and divider chain

  assign tick      = presc_q == 17'(TICK_CYCLES_P - 1);
  assign second_ms = 10'(base_q * rsq_pkg::RATIO_SECOND);
  assign third_ms  = 10'(base_q * rsq_pkg::RATIO_THIRD);

  // Prescaler cleared while held so the first tick is a full period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 17'h00000;
    end else if (cause || state_q != ST_RELEASE || tick) begin
      presc_q <= 17'h00000;
    end else begin
      presc_q <= presc_q + 17'h00001;
    end
  end

  // One elapsed count serves all three stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_q <= 10'h000;
    end else if (cause || state_q == ST_HOLD) begin
      ms_cnt_q <= 10'h000;
    end else if (state_q == ST_RELEASE && tick && ms_cnt_q != third_ms) begin
      ms_cnt_q <= ms_cnt_q + 10'h001;
    end
  end

  // Delay strap read while held; a change mid-release waits for the next hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= rsq_pkg::DLY_LOW_MS;
    end else if (state_q == ST_HOLD) begin
      base_q <= rsq_pkg::delay_ms(rsq_pkg::level_decode(delay_select));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_HOLD;
    end else if (cause) begin
      state_q <= ST_HOLD;
    end else begin
      case (state_q)
        ST_HOLD: begin
          state_q <= ST_RELEASE;
        end
        ST_RELEASE: begin
          if (!third_reset_out_n && ms_cnt_q == third_ms) begin
            state_q <= ST_RELEASE;
          end else if (third_reset_out_n) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
        default: begin
          state_q <= ST_HOLD;
        end
      endcase
    end
  end

  // Each stage gated by the one before, so order holds whatever the delays
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_reset_out_n <= 1'b0;
    end else if (cause) begin
      first_reset_out_n <= 1'b0;
    end else if (state_q == ST_RELEASE && ms_cnt_q >= base_q) begin
      first_reset_out_n <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_reset_out_n <= 1'b0;
    end else if (cause) begin
      second_reset_out_n <= 1'b0;
    end else if (state_q == ST_RELEASE && first_reset_out_n && ms_cnt_q >= second_ms) begin
      second_reset_out_n <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      third_reset_out_n <= 1'b0;
    end else if (cause) begin
      third_reset_out_n <= 1'b0;
    end else if (state_q == ST_RELEASE && second_reset_out_n && ms_cnt_q >= third_ms) begin
      third_reset_out_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply margin latch

  // Strap is only trusted while the supply is below every trip level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_trip_level <= rsq_pkg::MARGIN_RESET;
    end else if (supply_below_min) begin
      case (rsq_pkg::level_decode(supply_margin_select))
        rsq_pkg::LVL_HIGH: supply_trip_level <= rsq_pkg::MARGIN_5;
        rsq_pkg::LVL_LOW:  supply_trip_level <= rsq_pkg::MARGIN_10;
        default: begin
          supply_trip_level <= LOW_VOLT_VARIANT ? rsq_pkg::MARGIN_20
                                                : rsq_pkg::MARGIN_15;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state on every access

  assign access   = psel & penable;
  assign complete = access & pready;
  assign mapped   = paddr == rsq_pkg::ADDR_CTRL || paddr == rsq_pkg::ADDR_STATUS ||
                    paddr == rsq_pkg::ADDR_ELAPSED;

  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      rsq_pkg::ADDR_CTRL: begin
        rd_mux[rsq_pkg::CTRL_SOFT_HOLD] = soft_hold_q;
      end
      rsq_pkg::ADDR_STATUS: begin
        rd_mux[rsq_pkg::STAT_RST_LSB +: 3]    = {third_reset_out_n, second_reset_out_n,
                                                 first_reset_out_n};
        rd_mux[rsq_pkg::STAT_STATE_LSB +: 2]  = state_q;
        rd_mux[rsq_pkg::STAT_DELAY_LSB +: 2]  = rsq_pkg::level_decode(delay_select);
        rd_mux[rsq_pkg::STAT_MARGIN_LSB +: 2] = supply_trip_level;
        rd_mux[rsq_pkg::STAT_BUTTON]          = button_pressed;
        rd_mux[rsq_pkg::STAT_FAIL]            = supply_fail;
      end
      rsq_pkg::ADDR_ELAPSED: begin
        rd_mux[9:0] = ms_cnt_q;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  // Read data and error are captured in the wait cycle, held for the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~mapped;
    end else if (!access) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // Software hold acts like a held button without the debounce delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_hold_q <= rsq_pkg::CTRL_RESET;
    end else if (complete && pwrite && paddr == rsq_pkg::ADDR_CTRL && pstrb[0]) begin
      soft_hold_q <= pwdata[rsq_pkg::CTRL_SOFT_HOLD];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_fail_all_active: assert property (@(posedge pclk) disable iff (!presetn)
    supply_fail |=> !first_reset_out_n && !second_reset_out_n && !third_reset_out_n)
    else $error("Supply fail did not assert all resets");

  a_release_order: assert property (@(posedge pclk) disable iff (!presetn)
    (!first_reset_out_n |-> !second_reset_out_n) and
    (!second_reset_out_n |-> !third_reset_out_n))
    else $error("Reset outputs released out of order");

  a_stay_released: assert property (@(posedge pclk) disable iff (!presetn)
    (first_reset_out_n && !cause |=> first_reset_out_n) and
    (second_reset_out_n && !cause |=> second_reset_out_n) and
    (third_reset_out_n && !cause |=> third_reset_out_n))
    else $error("Released reset dropped without cause");

  a_base_decode: assert property (@(posedge pclk) disable iff (!presetn)
    $past(state_q) == ST_HOLD && state_q != ST_DONE && $past(presetn) |->
      base_q == rsq_pkg::delay_ms(rsq_pkg::level_decode($past(delay_select))))
    else $error("Base delay does not match delay select");

  a_first_min_time: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(first_reset_out_n) |-> ms_cnt_q == base_q && base_q >= rsq_pkg::DLY_LOW_MS)
    else $error("First reset released before its delay");

  a_second_ratio: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(second_reset_out_n) |-> ms_cnt_q == 10'(base_q * rsq_pkg::RATIO_SECOND))
    else $error("Second reset period not five times the first");

  a_third_ratio: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(third_reset_out_n) |-> ms_cnt_q == 10'(base_q * rsq_pkg::RATIO_THIRD))
    else $error("Third reset period not ten times the first");

  a_margin_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(supply_below_min) && $past(presetn) |-> $stable(supply_trip_level))
    else $error("Margin setting changed above lowest trip");

  a_margin_float: assert property (@(posedge pclk) disable iff (!presetn)
    supply_below_min && supply_margin_select[1] |=>
      supply_trip_level == (LOW_VOLT_VARIANT ? rsq_pkg::MARGIN_20 : rsq_pkg::MARGIN_15))
    else $error("Floating margin select decoded wrongly");

  a_restart_zero: assert property (@(posedge pclk) disable iff (!presetn)
    cause |=> ms_cnt_q == 10'h000 && state_q == ST_HOLD ##1 !cause [*2] |->
      state_q == ST_RELEASE)
    else $error("Cause did not restart the count");

  a_button_holds: assert property (@(posedge pclk) disable iff (!presetn)
    button_pressed [*2] |-> !first_reset_out_n)
    else $error("Held button did not keep resets active");

endmodule
`default_nettype wire

// ===== shared/rsq_pkg.sv
// Purpose: Constants, types and decode helpers for the staged reset sequencer
// Assumes: pclk at 125 MHz, APB register access, three-level straps given as 2-bit codes
// Notes:   Strap code 2'b00 tied low, 2'b01 tied high, 2'b1x left floating
//
// How it works
// - Supply out of tolerance drives all three resets active together.
// - After recovery release first, then second, then third reset only.
// - Released resets stay high until next supply fail or button press; the code also drops them while the software hold bit is set.
// - Delay select decodes tied high, tied low or floating into three delays.
// - Delay select low: first reset held at least 10 ms.
// - Delay select floating: first reset held at least 20 ms.
// - Delay select high: first reset held at least 50 ms.
// - Second reset active period is five times the first.
// - Third reset active period is ten times the first.
// - All delays come from one shared timebase and divider chain.
// - Margin select high picks 5 percent, low picks 10 percent.
// - Margin floating picks 15 percent on 5 V, 20 percent on 3.3 V.
// - Margin select sampled only below lowest trip level, then held.
// - Button press with resets inactive starts a complete new cycle.
// - While the button is held low all resets stay active.
// - Button release starts the staged release with current delay select.
// - Button input debounced and read as not pressed when undriven.
// - Stable button low asserts resets within 1.0 to 2.0 ms.
`default_nettype none
package rsq_pkg;

  typedef enum logic [1:0] {LVL_LOW, LVL_HIGH, LVL_FLOAT} rsq_level_e;
  typedef enum logic [1:0] {MARGIN_5, MARGIN_10, MARGIN_15, MARGIN_20} rsq_margin_e;

  // Clock and timebase
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYCLES    = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned QUALIFY_MIN_US = 1000;
  localparam int unsigned QUALIFY_CYCLES = (QUALIFY_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;

  // Base delays in timebase ticks (ms) and stage ratios
  localparam logic [9:0] DLY_LOW_MS   = 10'h00a;
  localparam logic [9:0] DLY_FLOAT_MS = 10'h014;
  localparam logic [9:0] DLY_HIGH_MS  = 10'h032;
  localparam logic [9:0] RATIO_SECOND = 10'h005;
  localparam logic [9:0] RATIO_THIRD  = 10'h00a;

  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_ELAPSED = 12'h008;

  // Field positions
  localparam int unsigned CTRL_SOFT_HOLD  = 0;
  localparam int unsigned STAT_RST_LSB    = 0;
  localparam int unsigned STAT_STATE_LSB  = 3;
  localparam int unsigned STAT_DELAY_LSB  = 5;
  localparam int unsigned STAT_MARGIN_LSB = 7;
  localparam int unsigned STAT_BUTTON     = 9;
  localparam int unsigned STAT_FAIL       = 10;

  // Reset values
  localparam logic        CTRL_RESET   = 1'b0;
  localparam rsq_margin_e MARGIN_RESET = MARGIN_10;

  function automatic rsq_level_e level_decode(input logic [1:0] pin);
    rsq_level_e lvl;
    lvl = LVL_FLOAT;
    if (pin == 2'b00) begin
      lvl = LVL_LOW;
    end else if (pin == 2'b01) begin
      lvl = LVL_HIGH;
    end
    return lvl;
  endfunction

  function automatic logic [9:0] delay_ms(input rsq_level_e lvl);
    logic [9:0] d;
    d = DLY_FLOAT_MS;
    case (lvl)
      LVL_LOW:  d = DLY_LOW_MS;
      LVL_HIGH: d = DLY_HIGH_MS;
      default:  d = DLY_FLOAT_MS;
    endcase
    return d;
  endfunction

endpackage
`default_nettype wire

// ===== testbench/rsq_partner.sv
// Purpose: Processor-side reset inputs and pushbutton pad beside the sequencer
// Assumes: Bench decides press and float timing through its request inputs
// Notes:   Stamps the cycle at which each reset input is released
`timescale 1ns/1ps
`default_nettype none
module rsq_partner (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Resets seen by the processor system
  input  wire logic first_reset_out_n,
  input  wire logic second_reset_out_n,
  input  wire logic third_reset_out_n,
  // Button requests from the bench
  input  wire logic press_req,
  input  wire logic float_req,
  // Button pad
  output logic      manual_reset_button_n,
  output logic      button_driven,
  // Observations
  output var int    cyc,
  output var int    rise1,
  output var int    rise2,
  output var int    rise3,
  output logic      order_err
);
  logic [2:0] prev_q;
  logic [2:0] cur;
  logic [2:0] rose;

  assign cur  = {third_reset_out_n, second_reset_out_n, first_reset_out_n};
  assign rose = cur & ~prev_q;

  // Undriven pad shows low: only the driven flag may make it read as released
  always_comb begin
    button_driven         = ~float_req;
    manual_reset_button_n = float_req ? 1'b0 : ~press_req;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q    <= 3'h0;
      cyc       <= 0;
      rise1     <= 0;
      rise2     <= 0;
      rise3     <= 0;
      order_err <= 1'b0;
    end else begin
      prev_q <= cur;
      cyc    <= cyc + 1;
      if (rose[0]) begin
        rise1 <= cyc;
      end
      if (rose[1]) begin
        rise2 <= cyc;
      end
      if (rose[2]) begin
        rise3 <= cyc;
      end
      // A later reset must never come free before the one ahead of it
      if ((rose[1] && !cur[0]) || (rose[2] && !cur[1])) begin
        order_err <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb_rsq_sequencer.sv
// Purpose: Self-checking bench for the staged reset sequencer
// Assumes: Short timebase and qualify counts so whole sequences fit the run
// Notes:   Release times are measured by the partner against the bench's start cycle
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module tb_rsq_sequencer;
  localparam int TK  = 4;
  localparam int QL  = 4;
  localparam int SLK = 16;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        supply_fail = 1'b1;
  logic        supply_below_min = 1'b1;
  logic [1:0]  delay_select = 2'b00;
  logic [1:0]  supply_margin_select = 2'b00;
  logic        manual_reset_button_n;
  logic        button_driven;
  logic        first_reset_out_n;
  logic        second_reset_out_n;
  logic        third_reset_out_n;
  logic [1:0]  supply_trip_level;
  logic        press_req = 1'b0;
  logic        float_req = 1'b0;
  logic        order_err;
  int          cyc;
  int          rise1;
  int          rise2;
  int          rise3;
  int          failures = 0;
  int          compares = 0;
  int          st;
  int          n;
  logic [31:0] rd;
  logic        er;
  wire logic [2:0] outs;
  logic [1:0]  dcode [3] = '{2'b00, 2'b10, 2'b01};
  logic [1:0]  ddec  [3] = '{2'h0, 2'h2, 2'h1};
  int          dbase [3] = '{10, 20, 50};
  logic [1:0]  mcode [3] = '{2'b00, 2'b01, 2'b10};
  logic [1:0]  mexp  [3] = '{2'h1, 2'h0, 2'h2};

  assign outs = {third_reset_out_n, second_reset_out_n, first_reset_out_n};

  always #4 pclk = ~pclk;

  rsq_sequencer #(.TICK_CYCLES_P(TK), .QUALIFY_CYCLES_P(QL), .LOW_VOLT_VARIANT(1'b0)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supply_fail(supply_fail), .supply_below_min(supply_below_min),
    .delay_select(delay_select), .supply_margin_select(supply_margin_select),
    .manual_reset_button_n(manual_reset_button_n), .button_driven(button_driven),
    .first_reset_out_n(first_reset_out_n), .second_reset_out_n(second_reset_out_n),
    .third_reset_out_n(third_reset_out_n), .supply_trip_level(supply_trip_level));

  rsq_partner i_partner (
    .pclk(pclk), .presetn(presetn), .first_reset_out_n(first_reset_out_n),
    .second_reset_out_n(second_reset_out_n), .third_reset_out_n(third_reset_out_n),
    .press_req(press_req), .float_req(float_req),
    .manual_reset_button_n(manual_reset_button_n), .button_driven(button_driven),
    .cyc(cyc), .rise1(rise1), .rise2(rise2), .rise3(rise3), .order_err(order_err));

  task automatic stop_test();
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    pstrb   <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      failures++;
      stop_test();
    end
  endtask

  // Times measured from the bench's start cycle, so a chained count shows up late
  task automatic run_seq(input int base, input int s);
    int u;
    int k;
    u = base * TK;
    for (k = 0; k < 12 * u + 200 && third_reset_out_n !== 1'b1; k++) @(posedge pclk);
    if (k >= 12 * u + 200) begin
      failures++;
      stop_test();
    end
    @(posedge pclk);
    `CHK("first_time", 1'b1, rise1 - s >= u && rise1 - s <= u + SLK)
    `CHK("second_time", 1'b1, rise2 - s >= 5 * u && rise2 - s <= 5 * u + SLK)
    `CHK("third_time", 1'b1, rise3 - s >= 10 * u && rise3 - s <= 10 * u + SLK)
    repeat (50) @(posedge pclk);
    `CHK("stay_high", 3'h7, outs)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("rst_on_fail", 3'h0, outs)
    for (int i = 0; i < 3; i++) begin
      supply_margin_select <= mcode[i];
      repeat (3) @(posedge pclk);
      `CHK("trip_level", mexp[i], supply_trip_level)
    end
    supply_below_min     <= 1'b0;
    supply_margin_select <= 2'b00;
    repeat (3) @(posedge pclk);
    `CHK("trip_held", 2'h2, supply_trip_level)
    for (int i = 0; i < 3; i++) begin
      supply_fail  <= 1'b1;
      delay_select <= dcode[i];
      repeat (4) @(posedge pclk);
      `CHK("rst_on_fail", 3'h0, outs)
      supply_fail <= 1'b0;
      st = cyc;
      run_seq(dbase[i], st);
      apb(12'h004, 1'b0, 32'h0, rd, er);
      `CHK("status_outs", 3'h7, rd[2:0])
      `CHK("status_delay", ddec[i], rd[6:5])
      `CHK("status_state", 2'h2, rd[4:3])
      `CHK("status_margin", 2'h2, rd[8:7])
      `CHK("status_flags", 2'h0, rd[10:9])
      apb(12'h008, 1'b0, 32'h0, rd, er);
      `CHK("elapsed", 10'(10 * dbase[i]), rd[9:0])
    end
    // Fresh failure in mid-sequence must restart every count
    supply_fail  <= 1'b1;
    delay_select <= 2'b00;
    repeat (4) @(posedge pclk);
    supply_fail <= 1'b0;
    for (n = 0; n < 200 && first_reset_out_n !== 1'b1; n++) @(posedge pclk);
    if (n >= 200) begin
      failures++;
      stop_test();
    end
    supply_fail <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("restart_low", 3'h0, outs)
    supply_fail <= 1'b0;
    st = cyc;
    run_seq(10, st);
    press_req <= 1'b1;
    repeat (2) @(posedge pclk);
    press_req <= 1'b0;
    repeat (20) @(posedge pclk);
    `CHK("glitch_ignored", 3'h7, outs)
    float_req <= 1'b1;
    repeat (30) @(posedge pclk);
    `CHK("float_ignored", 3'h7, outs)
    float_req <= 1'b0;
    press_req <= 1'b1;
    for (n = 0; n < 100 && first_reset_out_n !== 1'b0; n++) @(posedge pclk);
    if (n >= 100) begin
      failures++;
      stop_test();
    end
    `CHK("qualify_delay", 1'b1, n >= QL && n <= 2 * QL)
    `CHK("press_all_low", 3'h0, outs)
    repeat (300) @(posedge pclk);
    `CHK("held_low", 3'h0, outs)
    press_req <= 1'b0;
    st = cyc;
    run_seq(10, st);
    apb(12'h00c, 1'b0, 32'h0, rd, er);
    `CHK("unmapped_err", 1'b1, er)
    `CHK("unmapped_data", 32'h0, rd)
    apb(12'h000, 1'b1, 32'h1, rd, er);
    repeat (3) @(posedge pclk);
    `CHK("soft_hold_low", 3'h0, outs)
    apb(12'h000, 1'b1, 32'h0, rd, er);
    st = cyc;
    run_seq(10, st);
    `CHK("order_kept", 1'b0, order_err)
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
